// File: pairing_defines.vh
`ifndef PAIRING_DEFINES_VH
`define PAIRING_DEFINES_VH

////////////////////////////////////////////////////////////////////////////////
// Instruction word layout
`define INSN_W          16
`define REG2_HI         15
`define REG2_LO         11
`define OPC_HI          10
`define OPC_LO          5
`define REG1_HI         4
`define REG1_LO         0
`define COND_HI         3
`define COND_LO         0

////////////////////////////////////////////////////////////////////////////////
// Register numbers
`define REG_ZERO        5'h00
`define REG_EBP         5'h1E

////////////////////////////////////////////////////////////////////////////////
// Register-register format opcodes
`define OP_MOV          6'h00
`define OP_NOT          6'h01
`define OP_EXT          6'h03
`define OP_SATSUBR      6'h04
`define OP_SATSUB       6'h05
`define OP_SATADD       6'h06
`define OP_MULH         6'h07
`define OP_OR           6'h08
`define OP_XOR          6'h09
`define OP_AND          6'h0A
`define OP_TST          6'h0B
`define OP_SUBR         6'h0C
`define OP_SUB          6'h0D
`define OP_ADD          6'h0E
`define OP_CMP          6'h0F

////////////////////////////////////////////////////////////////////////////////
// Immediate format opcodes
`define OP_MOV_I        6'h10
`define OP_SATADD_I     6'h11
`define OP_ADD_I        6'h12
`define OP_CMP_I        6'h13
`define OP_SHR_I        6'h14
`define OP_SAR_I        6'h15
`define OP_SHL_I        6'h16
`define OP_MULH_I       6'h17

////////////////////////////////////////////////////////////////////////////////
// Branch format: opcode top four bits, condition code of the always-taken form
`define OP_BCC_TOP      4'hB
`define COND_ALWAYS     4'h5

////////////////////////////////////////////////////////////////////////////////
// Short pointer-relative load/store: opcode top two bits, store flag bit
`define OP_SHORT_TOP    2'h3
`define OP_STORE_BIT    3

////////////////////////////////////////////////////////////////////////////////
// Class vector bit positions
`define CLS_W           10
`define CLS_MOV         0
`define CLS_FUSE_OP     1
`define CLS_PRE_BR      2
`define CLS_PRE_BCC     3
`define CLS_PRE_SLD     4
`define CLS_BR          5
`define CLS_BCC         6
`define CLS_SLD         7
`define CLS_FLAGS       8
`define CLS_WR_EBP      9

////////////////////////////////////////////////////////////////////////////////
// Issue kinds on the issue_kind output
`define KIND_SINGLE     2'h0
`define KIND_FUSED      2'h1
`define KIND_PARALLEL   2'h2

`endif

// File: insn_class.v
`include "pairing_defines.vh"

module insn_class (
  // Instruction to classify
  input  wire [`INSN_W-1:0] insn,
  // Class vector and destination
  output reg  [`CLS_W-1:0]  cls,
  output wire [4:0]         dst
);

  wire [5:0] opc;
  wire [4:0] reg1;
  wire [4:0] reg2;
  wire       is_short;
  wire       is_store;
  wire       is_branch;
  wire       is_always;

  assign opc       = insn[`OPC_HI:`OPC_LO];
  assign reg1      = insn[`REG1_HI:`REG1_LO];
  assign reg2      = insn[`REG2_HI:`REG2_LO];
  assign is_short  = (opc[5:4] == `OP_SHORT_TOP);
  assign is_store  = is_short & opc[`OP_STORE_BIT];
  assign is_branch = (opc[5:2] == `OP_BCC_TOP);
  assign is_always = (insn[`COND_HI:`COND_LO] == `COND_ALWAYS);
  // Extension ops write their single operand field
  assign dst       = (opc == `OP_EXT) ? reg1 : reg2;

  // Opcode to class; anything unlisted other than branches and short accesses gets no pairing class and counts as flag-writing
  always @* begin
    cls = {`CLS_W{1'b0}};
    cls[`CLS_FLAGS] = 1'b1;
    case (opc)
      `OP_MOV, `OP_MOV_I: begin
        cls[`CLS_MOV]     = (opc == `OP_MOV);
        cls[`CLS_PRE_BR]  = 1'b1;
        cls[`CLS_PRE_BCC] = 1'b1;
        cls[`CLS_PRE_SLD] = 1'b1;
        cls[`CLS_FLAGS]   = 1'b0;
      end
      `OP_MULH, `OP_MULH_I: begin
        cls[`CLS_FUSE_OP] = 1'b1;
        cls[`CLS_PRE_BR]  = 1'b1;
        cls[`CLS_PRE_BCC] = 1'b1;
        cls[`CLS_PRE_SLD] = 1'b1;
        cls[`CLS_FLAGS]   = 1'b0;
      end
      `OP_EXT: begin
        cls[`CLS_PRE_BCC] = 1'b1;
        cls[`CLS_FLAGS]   = 1'b0;
      end
      // Immediate add forms may lead a pair but never fuse with a move
      `OP_NOT, `OP_TST, `OP_CMP, `OP_CMP_I, `OP_SATADD_I, `OP_ADD_I: begin
        cls[`CLS_PRE_BR]  = 1'b1;
        cls[`CLS_PRE_SLD] = 1'b1;
      end
      `OP_SATSUBR, `OP_SATSUB, `OP_SATADD, `OP_OR, `OP_XOR, `OP_AND,
      `OP_SUBR, `OP_SUB, `OP_ADD,
      `OP_SHR_I, `OP_SAR_I, `OP_SHL_I: begin
        cls[`CLS_FUSE_OP] = 1'b1;
        cls[`CLS_PRE_BR]  = 1'b1;
        cls[`CLS_PRE_SLD] = 1'b1;
      end
      default: begin
        if (is_branch) begin
          cls[`CLS_BR]    = is_always;
          cls[`CLS_BCC]   = ~is_always;
          cls[`CLS_FLAGS] = 1'b0;
        end else if (is_short) begin
          cls[`CLS_SLD]     = ~is_store;
          cls[`CLS_PRE_BR]  = 1'b1;
          cls[`CLS_PRE_BCC] = 1'b1;
          cls[`CLS_FLAGS]   = 1'b0;
        end
      end
    endcase
    // Base pointer write: any register-writing form aimed at it
    cls[`CLS_WR_EBP] = (dst == `REG_EBP) & ~is_store & ~is_branch & (opc != `OP_TST)
                       & (opc != `OP_CMP) & (opc != `OP_CMP_I);
  end

endmodule

// File: dual_issue_pairing.v
`include "pairing_defines.vh"

// How it works
// - Move then same-destination arithmetic, logic or shift op fuses, destination not r0
// - Fusion only when the move comes first; reverse order never fuses
// - Unconditional branch pairs after nop, move, arithmetic, logic, shift or short access
// - Conditional branch pairs only after non-flag-updating ops or short access
// - Short load pairs after nop, move, not, compare, test, arithmetic, logic, shift
// - Parallel issue only with a later branch or short load; other later ops fuse after a move or issue alone
// - No pairing for the first instruction after a branch to misaligned target
// - No short-load pairing while a base pointer write awaits writeback
// - No conditional-branch pairing when either of two prior ops may set flags
// - No short-load pairing while both load buffers wait for writeback
module dual_issue_pairing #(
  parameter LOAD_BUFS = 2
) (
  // Clock and reset
  input  wire                 clk,
  input  wire                 reset_n,
  // Fetch slots: slot0 is the earlier instruction
  input  wire                 slot0_valid,
  input  wire [`INSN_W-1:0]   slot0_insn,
  input  wire                 slot1_valid,
  input  wire [`INSN_W-1:0]   slot1_insn,
  // Fetch redirect: pulse with low bits of the branch target
  input  wire                 redirect,
  input  wire [1:0]           redirect_addr,
  // Writeback and load buffer state
  input  wire                 ebp_wb_pending,
  input  wire [LOAD_BUFS-1:0] load_buf_wait,
  // Execute stage ready to take an issue
  input  wire                 issue_ready,
  // Slot consumption, handshake to fetch
  output wire                 take_slot0,
  output wire                 take_slot1,
  // Issued operation
  output reg                  issue_valid_r,
  output reg  [1:0]           issue_kind_r,
  output reg  [`INSN_W-1:0]   issue_insn0_r,
  output reg  [`INSN_W-1:0]   issue_insn1_r,
  // Why a candidate pair was kept apart
  output reg                  blk_misalign_r,
  output reg                  blk_ebp_r,
  output reg                  blk_flags_r,
  output reg                  blk_loadbuf_r
);

  ////////////////////////////////////////////////////////////////////////////////
  // Classification of both slots

  wire [2*`CLS_W-1:0] cls_bus;
  wire [9:0]          dst_bus;
  wire [2*`INSN_W-1:0] insn_bus;

  assign insn_bus = {slot1_insn, slot0_insn};

  // One classifier per slot
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1) begin : g_slot
      insn_class u_cls (
        .insn (insn_bus[s*`INSN_W +: `INSN_W]),
        .cls  (cls_bus[s*`CLS_W +: `CLS_W]),
        .dst  (dst_bus[s*5 +: 5])
      );
    end
  endgenerate

  wire [`CLS_W-1:0] c0;
  wire [`CLS_W-1:0] c1;
  wire [4:0]        d0;
  wire [4:0]        d1;

  assign c0 = cls_bus[`CLS_W-1:0];
  assign c1 = cls_bus[2*`CLS_W-1:`CLS_W];
  assign d0 = dst_bus[4:0];
  assign d1 = dst_bus[9:5];

  ////////////////////////////////////////////////////////////////////////////////
  // Pipeline history state

  reg misalign_first_r;
  reg misalign_first_nxt;
  reg prev_flags_r;
  reg prev_flags_nxt;

  wire issue_go;
  wire pair_go;

  assign issue_go = slot0_valid & issue_ready;

  // First fetch after a redirect to a non-word-aligned target; cleared once it issues
  always @* begin
    misalign_first_nxt = misalign_first_r;
    if (issue_go)
      misalign_first_nxt = 1'b0;
    if (redirect)
      misalign_first_nxt = redirect_addr[1];  // redirect wins over the clear
  end

  // Flag writer status of the most recently issued instruction
  always @* begin
    prev_flags_nxt = prev_flags_r;
    if (redirect)
      prev_flags_nxt = 1'b0;
    else if (issue_go)
      prev_flags_nxt = pair_go ? c1[`CLS_FLAGS] : c0[`CLS_FLAGS];
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      misalign_first_r <= 1'b0;
      prev_flags_r     <= 1'b0;
    end else begin
      misalign_first_r <= misalign_first_nxt;
      prev_flags_r     <= prev_flags_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Candidate pairings

  wire fuse_ok;
  wire br_ok;
  wire bcc_ok;
  wire sld_ok;
  wire par_cand;

  // Fusion keys on slot0 being the move; slot1 move never fuses with slot0
  assign fuse_ok = c0[`CLS_MOV] & c1[`CLS_FUSE_OP]
                   & (d0 == d1) & (d0 != `REG_ZERO);

  // Parallel candidates by later-instruction kind
  assign br_ok  = c1[`CLS_BR]  & c0[`CLS_PRE_BR];
  assign bcc_ok = c1[`CLS_BCC] & c0[`CLS_PRE_BCC];
  assign sld_ok = c1[`CLS_SLD] & c0[`CLS_PRE_SLD];

  // Only these three later kinds ever go parallel
  assign par_cand = br_ok | bcc_ok | sld_ok;

  ////////////////////////////////////////////////////////////////////////////////
  // Pairing blockers

  wire blk_misalign;
  wire blk_ebp;
  wire blk_flags;
  wire blk_loadbuf;
  wire any_block;
  wire pair_cand;

  assign pair_cand = slot1_valid & (fuse_ok | par_cand);

  // Misaligned entry point never pairs, fused or parallel
  assign blk_misalign = misalign_first_r;

  // Base pointer not yet written back, or written by the partner in slot0
  assign blk_ebp = sld_ok & (ebp_wb_pending | c0[`CLS_WR_EBP]);

  // Either of the two preceding instructions may still change the flags
  assign blk_flags = bcc_ok & (c0[`CLS_FLAGS] | prev_flags_r);

  // Every load buffer held by a load still waiting for writeback
  assign blk_loadbuf = sld_ok & (&load_buf_wait);

  assign any_block = blk_misalign | blk_ebp | blk_flags | blk_loadbuf;
  assign pair_go   = issue_go & pair_cand & ~any_block;

  // Fetch may drop slot1 only when it left in the same issue
  assign take_slot0 = issue_go;
  assign take_slot1 = pair_go;

  ////////////////////////////////////////////////////////////////////////////////
  // Issue register

  reg [1:0] kind_nxt;

  // Fusion takes priority: a fused pair is a single operation, not two lanes
  always @* begin
    kind_nxt = `KIND_SINGLE;
    if (pair_go) begin
      if (fuse_ok)
        kind_nxt = `KIND_FUSED;
      else
        kind_nxt = `KIND_PARALLEL;
    end
  end

  // Output stage holds its value while execute is not ready
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      issue_valid_r <= 1'b0;
      issue_kind_r  <= `KIND_SINGLE;
      issue_insn0_r <= {`INSN_W{1'b0}};
      issue_insn1_r <= {`INSN_W{1'b0}};
    end else if (issue_ready) begin
      issue_valid_r <= slot0_valid;
      issue_kind_r  <= kind_nxt;
      issue_insn0_r <= slot0_insn;
      issue_insn1_r <= pair_go ? slot1_insn : {`INSN_W{1'b0}};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Block reason flags, one issue wide; only raised for a real candidate pair

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      blk_misalign_r <= 1'b0;
      blk_ebp_r      <= 1'b0;
      blk_flags_r    <= 1'b0;
      blk_loadbuf_r  <= 1'b0;
    end else if (issue_ready) begin
      blk_misalign_r <= issue_go & pair_cand & blk_misalign;
      blk_ebp_r      <= issue_go & pair_cand & blk_ebp;
      blk_flags_r    <= issue_go & pair_cand & blk_flags;
      blk_loadbuf_r  <= issue_go & pair_cand & blk_loadbuf;
    end
  end

endmodule

// File: dual_issue_pairing_chk.sv
`include "pairing_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Port-level checks of the pairing decision
module dual_issue_pairing_chk #(
  parameter LOAD_BUFS = 2
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 reset_n,
  // Block inputs
  input wire logic                 slot0_valid,
  input wire logic [15:0]          slot0_insn,
  input wire logic [15:0]          slot1_insn,
  input wire logic                 ebp_wb_pending,
  input wire logic [LOAD_BUFS-1:0] load_buf_wait,
  input wire logic                 issue_ready,
  // Block outputs
  input wire logic                 take_slot0,
  input wire logic                 take_slot1,
  input wire logic [1:0]           issue_kind_r,
  input wire logic [15:0]          issue_insn0_r,
  input wire logic [15:0]          issue_insn1_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Own decode of the later slot and of a compare in slot0, so a decoder slip cannot hide itself
  wire sld1 = slot1_insn[10:9] == 2'h3 && !slot1_insn[8];
  wire par1 = sld1 || slot1_insn[10:7] == 4'hB;
  wire bcc1 = slot1_insn[10:7] == 4'hB && slot1_insn[3:0] != 4'h5;
  wire cmp0 = slot0_insn[10:5] == `OP_CMP || slot0_insn[10:5] == `OP_CMP_I;

  a_take_comb: assert property (take_slot0 == (slot0_valid && issue_ready))
    else $error("take_slot0 wrong");
  a_insn_capture: assert property (take_slot0 |=> issue_insn0_r == $past(slot0_insn))
    else $error("issued word wrong");
  a_single_kind: assert property (take_slot0 && !take_slot1 |=>
    issue_kind_r == `KIND_SINGLE && issue_insn1_r == 16'h0000) else $error("single wrong");
  a_pair_kind: assert property (take_slot1 |=>
    issue_kind_r != `KIND_SINGLE && issue_insn1_r == $past(slot1_insn)) else $error("pair wrong");
  a_fuse_order: assert property (take_slot1 && slot0_insn[10:5] != `OP_MOV |=>
    issue_kind_r == `KIND_PARALLEL) else $error("fused without leading move");
  a_par_later: assert property (take_slot1 && !par1 |=> issue_kind_r == `KIND_FUSED)
    else $error("parallel with wrong later op");
  a_ebp_block: assert property (ebp_wb_pending && sld1 |-> !take_slot1)
    else $error("short load paired over pending base write");
  a_lbuf_block: assert property ((&load_buf_wait) && sld1 |-> !take_slot1)
    else $error("short load paired with buffers full");
  a_zero_nofuse: assert property (slot0_insn[15:5] == 11'h000 && !par1 |-> !take_slot1)
    else $error("fused into register zero");
  a_flag_block: assert property (bcc1 && cmp0 |-> !take_slot1)
    else $error("conditional branch paired after compare");

  c_fused: cover property (take_slot1 && !par1);
  c_parallel: cover property (take_slot1 && par1);
  c_blocked: cover property (take_slot0 && ebp_wb_pending && sld1);
endmodule

bind dual_issue_pairing dual_issue_pairing_chk #(.LOAD_BUFS(LOAD_BUFS)) chk_i (
  .clk(clk), .reset_n(reset_n), .slot0_valid(slot0_valid), .slot0_insn(slot0_insn),
  .slot1_insn(slot1_insn), .ebp_wb_pending(ebp_wb_pending), .load_buf_wait(load_buf_wait),
  .issue_ready(issue_ready), .take_slot0(take_slot0), .take_slot1(take_slot1),
  .issue_kind_r(issue_kind_r), .issue_insn0_r(issue_insn0_r), .issue_insn1_r(issue_insn1_r));

// File: writeback_model.sv
////////////////////////////////////////////////////////////////////////////////
// Writeback and load buffer stage as the pairing block sees it
module writeback_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Mode: 0 idle, 1 random stalls, 2 everything waiting
  input  wire logic [1:0] mode,
  // State offered to the pairing block
  output logic            ebp_wb_pending,
  output logic [1:0]      load_buf_wait
);
  timeunit 1ns;
  timeprecision 1ps;
  integer seed = 7;
  // Falling-edge updates keep the state settled at the sampling edge
  always @(negedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ebp_wb_pending <= 1'h0;
      load_buf_wait  <= 2'h0;
    end else begin
      ebp_wb_pending <= mode == 2'h2 || (mode == 2'h1 && $random(seed) % 3 == 0);
      load_buf_wait  <= mode == 2'h2 ? 2'h3 : (mode == 2'h1 ? 2'($random(seed)) : 2'h0);
    end
  end
endmodule

// File: dual_issue_pairing_tb.sv
`include "pairing_defines.vh"

////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the pairing block
module dual_issue_pairing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'h0, reset_n = 1'h0, redirect = 1'h0, issue_ready = 1'h0;
  logic        slot0_valid = 1'h0, slot1_valid = 1'h0, h_mis = 1'h0, h_flag = 1'h0;
  logic [15:0] slot0_insn = 16'h0000, slot1_insn = 16'h0000, a, b;
  logic [1:0]  redirect_addr = 2'h0, wb_mode = 2'h0, load_buf_wait, issue_kind_r;
  logic        ebp_wb_pending, take_slot0, take_slot1, issue_valid_r;
  logic [15:0] issue_insn0_r, issue_insn1_r;
  logic        blk_misalign_r, blk_ebp_r, blk_flags_r, blk_loadbuf_r;
  integer      seed = 52434, error_cnt = 0, cmp_count = 0, i;

  always #5 clk = ~clk;

  dual_issue_pairing dual_issue_pairing_i (.clk(clk), .reset_n(reset_n),
    .slot0_valid(slot0_valid), .slot0_insn(slot0_insn), .slot1_valid(slot1_valid),
    .slot1_insn(slot1_insn), .redirect(redirect), .redirect_addr(redirect_addr),
    .ebp_wb_pending(ebp_wb_pending), .load_buf_wait(load_buf_wait),
    .issue_ready(issue_ready), .take_slot0(take_slot0), .take_slot1(take_slot1),
    .issue_valid_r(issue_valid_r), .issue_kind_r(issue_kind_r),
    .issue_insn0_r(issue_insn0_r), .issue_insn1_r(issue_insn1_r),
    .blk_misalign_r(blk_misalign_r), .blk_ebp_r(blk_ebp_r), .blk_flags_r(blk_flags_r),
    .blk_loadbuf_r(blk_loadbuf_r));
  writeback_model writeback_model_i (.clk(clk), .reset_n(reset_n), .mode(wb_mode),
    .ebp_wb_pending(ebp_wb_pending), .load_buf_wait(load_buf_wait));

  ////////////////////////////////////////////////////////////////////////////////
  // Classes: 0 move, 1 fusable, 2/3/4 may lead br/bcc/sld, 5 br, 6 bcc, 7 sld, 8 flags
  function automatic logic [8:0] cls(input logic [15:0] w);
    logic [5:0] o;
    o = w[10:5];
    cls[0] = o == 6'h00;
    cls[1] = (o >= 6'h04 && o <= 6'h0E && o != 6'h0B) || (o >= 6'h14 && o <= 6'h17);
    cls[2] = o < 6'h02 || (o >= 6'h04 && o < 6'h18) || o >= 6'h30;
    cls[3] = o == 6'h00 || o == 6'h03 || o == 6'h07 || o == 6'h10 || o == 6'h17 || o >= 6'h30;
    cls[4] = o < 6'h02 || (o >= 6'h04 && o < 6'h18);
    cls[5] = o[5:2] == 4'hB && w[3:0] == 4'h5;
    cls[6] = o[5:2] == 4'hB && w[3:0] != 4'h5;
    cls[7] = o[5:4] == 2'h3 && !o[3];
    cls[8] = !(cls[3] || cls[5] || cls[6]);
  endfunction

  // Random traffic keeps clear of the base pointer; a directed corner covers it
  function automatic logic [15:0] fix(input logic [15:0] r);
    if (r[15:11] == 5'h1E) r[15:11] = 5'h1D;
    if (r[4:0] == 5'h1E) r[4:0] = 5'h1D;
    return r;
  endfunction

  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One cycle; ctl = {slot0 valid, slot1 valid, ready, redirect, misaligned target}
  task automatic step(input logic [15:0] w0, input logic [15:0] w1, input logic [4:0] ctl);
    logic [8:0] c0, c1;
    logic       fz, cand, bf, be, bl, pair;
    @(negedge clk);
    slot0_insn = w0;
    slot1_insn = w1;
    {slot0_valid, slot1_valid, issue_ready, redirect} = ctl[4:1];
    redirect_addr = {ctl[0], 1'h0};
    #1;
    c0 = cls(w0);
    c1 = cls(w1);
    fz = c0[0] && c1[1] && w0[15:11] == w1[15:11] && w0[15:11] != 5'h00;
    cand = ctl[4] && ctl[3] && (fz || (c1[5] && c0[2]) || (c1[6] && c0[3]) || (c1[7] && c0[4]));
    bf = c1[6] && h_flag;
    be = c1[7] && (ebp_wb_pending ||
         (w0[15:11] == 5'h1E && !(w0[10:5] inside {6'h0B, 6'h0F, 6'h13})));
    bl = c1[7] && (&load_buf_wait);
    pair = cand && !h_mis && !bf && !be && !bl;
    chk_val("take_slot0", ctl[4] && ctl[2], take_slot0);
    chk_val("take_slot1", pair && ctl[2], take_slot1);
    @(posedge clk);
    #1;
    if (ctl[2]) begin
      chk_val("issue_valid", ctl[4], issue_valid_r);
      if (ctl[4]) begin
        chk_val("kind", pair ? (fz ? `KIND_FUSED : `KIND_PARALLEL) : `KIND_SINGLE, issue_kind_r);
        chk_val("insn0", w0, issue_insn0_r);
        chk_val("insn1", pair ? w1 : 16'h0000, issue_insn1_r);
        chk_val("blk_misalign", cand && h_mis, blk_misalign_r);
        chk_val("blk_ebp", cand && be, blk_ebp_r);
        chk_val("blk_flags", cand && bf, blk_flags_r);
        chk_val("blk_loadbuf", cand && bl, blk_loadbuf_r);
        h_mis = 1'h0;
        h_flag = pair ? c1[8] : c0[8];
      end
    end
    // A redirect overrides the history of an issue in the same cycle
    if (ctl[1]) begin
      h_mis = ctl[0];
      h_flag = 1'h0;
    end
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Directed corners, then random traffic with stalls from the writeback side
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'h1;
    step(16'h2806, 16'h29C7, 5'h1C);
    step(16'h0006, 16'h01C7, 5'h1C);
    step(16'h29C7, 16'h2806, 5'h1C);
    for (i = 0; i < 256; i++) begin
      step(16'h0000, 16'h0000, 5'h14);
      a = i < 192 ? {5'h02, i[5:0], 5'h03} : 16'h1003;
      b = i < 64 ? 16'h0585 : i < 128 ? 16'h0582 : i < 192 ? 16'h1E04 : {5'h02, i[5:0], 5'h07};
      step(a, b, 5'h1C);
    end
    step(16'h0000, 16'h0000, 5'h1B);
    step(16'h1003, 16'h0585, 5'h1C);
    step(16'h1003, 16'h0585, 5'h1C);
    step(16'h11E3, 16'h0000, 5'h14);
    step(16'h1003, 16'h0582, 5'h1C);
    step(16'hF003, 16'h1E04, 5'h1C);
    wb_mode <= 2'h2;
    step(16'h1003, 16'h1E04, 5'h1C);
    step(16'h1003, 16'h1E04, 5'h1C);
    wb_mode <= 2'h1;
    for (i = 0; i < 2000; i++) begin
      a = fix($random(seed));
      b = fix($random(seed));
      if (a[0]) a[10:5] = 6'h00;
      if (b[1]) b[15:11] = a[15:11];
      step(a, b, {$random(seed) % 8 != 0, $random(seed) % 8 != 0, $random(seed) % 4 != 0,
                  $random(seed) % 8 == 0, $random(seed) % 2 == 0});
    end
    close_out();
  end

  // About 2500 cycles are needed; the limit leaves ample margin
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
endmodule
